// ---- inc/flash_seq_pkg.sv ----
// shared constants, field layouts and carrier types of the flash sequencer
package flash_seq_pkg;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int MCLK_PERIOD_NS = 8;
    localparam int MCLK_FREQ_KHZ = 1000000 / MCLK_PERIOD_NS;
    localparam int OSC_FREQ_KHZ = 7370;
    localparam int TUNE_STEP_KHZ = 28;
    localparam int ROW_OSC_CYCLES = 11064;
    localparam int PAGE_OSC_CYCLES = 100000;
    localparam int WORD_OSC_CYCLES = 1000;
    // ----------------------------------------------------------------
    // array geometry; sizes in words, address widths in program address units (two per word)
    // ----------------------------------------------------------------
    localparam int ROW_WORDS = 64;
    localparam int PAGE_ROWS = 8;
    localparam int PAGE_WORDS = ROW_WORDS * PAGE_ROWS;
    localparam int ROW_ADDR_BITS = 7;
    localparam int PAGE_ADDR_BITS = 10;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_KEY = 5'h04;
    localparam logic [4:0] OFF_PAGE = 5'h08;
    localparam logic [4:0] OFF_PTR = 5'h0c;
    localparam logic [4:0] OFF_LOW = 5'h10;
    localparam logic [4:0] OFF_HIGH = 5'h14;
    localparam logic [4:0] OFF_STAT = 5'h18;
    localparam logic [4:0] OFF_TUNE = 5'h1c;
    // ----------------------------------------------------------------
    // fields and codes
    // ----------------------------------------------------------------
    localparam int CTRL_START_BIT = 15;
    localparam int CTRL_WREN_BIT = 14;
    localparam int CTRL_ERR_BIT = 13;
    localparam int CTRL_ERASE_BIT = 6;
    localparam int PTR_BYTE_BIT = 16;
    localparam logic [3:0] OP_ROW = 4'h1;
    localparam logic [3:0] OP_PAGE = 4'h2;
    localparam logic [3:0] OP_WORD = 4'h3;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [15:0] PTR_RESET = 16'h0000;
    localparam logic [5:0] TUNE_RESET = 6'h00;

    typedef struct packed {
        logic start;
        logic wren;
        logic err;
        logic erase;
        logic [3:0] op;
    } flash_ctrl_t;

    localparam flash_ctrl_t CTRL_RESET = '0;

    typedef struct packed {
        logic read;
        logic write;
        logic erase;
        logic cfgSpace;
        logic [23:0] addr;
        logic [23:0] data;
    } flash_cmd_t;
endpackage

// ---- verilog/holding_buffer.sv ----
// 64-entry by 24-bit holding buffer with byte-lane writes and registered read
`timescale 1ns/10ps
module holding_buffer (
    input wire logic mclk,
    input wire logic [2:0] wrLanes,
    input wire logic [5:0] wrIdx,
    input wire logic [23:0] wrData,
    input wire logic [5:0] rdIdx,
    output logic [23:0] rdData
);
    import flash_seq_pkg::*;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : lane
            logic [7:0] mem [0:ROW_WORDS-1];
            logic [7:0] rdq;
            always_ff @(posedge mclk) begin
                if (wrLanes[g]) begin
                    mem[wrIdx] <= wrData[8*g +: 8];
                end
                rdq <= mem[rdIdx];
            end
            assign rdData[8*g +: 8] = rdq;
        end
    endgenerate
endmodule

// ---- verilog/op_timer.sv ----
// self-timed operation counter paced by an emulated internal_fast_oscillator
`timescale 1ns/10ps
module op_timer (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic [17:0] oscCycles,
    input wire logic [5:0] tune,
    output logic done
);
    import flash_seq_pkg::*;

    localparam logic [17:0] MCLK_K = 18'(MCLK_FREQ_KHZ);
    logic [17:0] tuneAdj;
    logic [17:0] sum;
    logic [17:0] acc_reg;
    logic [17:0] cnt_reg;
    logic running_reg;

    // signed tuning step, wraps correctly in 18 bits
    assign tuneAdj = 18'({{12{tune[5]}}, tune} * 18'(TUNE_STEP_KHZ));
    // fractional accumulator: one tick per oscillator period
    assign sum = acc_reg + 18'(OSC_FREQ_KHZ) + tuneAdj;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            acc_reg <= '0;
            cnt_reg <= '0;
            running_reg <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                acc_reg <= '0;
                cnt_reg <= oscCycles;
                running_reg <= 1'b1;
            end else if (running_reg) begin
                if (sum >= MCLK_K) begin
                    acc_reg <= sum - MCLK_K;
                    cnt_reg <= cnt_reg - 18'h1;
                    if (cnt_reg <= 18'h1) begin
                        running_reg <= 1'b0;
                        done <= 1'b1;
                    end
                end else begin
                    acc_reg <= sum;
                end
            end
        end
    end
endmodule

// ---- verilog/flash_row_program_sequencer.sv ----
// flash sequencer: bus slave, unlock key, holding buffer, timed program and erase
`timescale 1ns/10ps
// Operation
// - rows hold 64 words, 192 bytes
// - erase page is eight rows, 512 words
// - pages and rows aligned from memory start
// - program a full row or one word
// - table writes fill 64-word holding buffer
// - buffer table write is a short write
// - one programming cycle per row
// - core stalled until operation completes
// - start bit 15 self-clears when done
// - target address is page above address
// - low access: bits 15:0, word or byte
// - high access: bits 23:16, word or byte
// - operation timed from fast internal oscillator
// - key 0x55 then 0xaa before start
// - high word read returns zero upper byte
// - page bit 7 selects configuration space
module flash_row_program_sequencer #(
    parameter int ROW_CYCLES = flash_seq_pkg::ROW_OSC_CYCLES,
    parameter int PAGE_CYCLES = flash_seq_pkg::PAGE_OSC_CYCLES,
    parameter int WORD_CYCLES = flash_seq_pkg::WORD_OSC_CYCLES
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output flash_seq_pkg::flash_cmd_t arrCmd,
    input wire logic [23:0] arrRdData,
    output logic coreStall
);
    import flash_seq_pkg::*;

    typedef enum {BUS_IDLE, BUS_WAIT, BUS_DATA, BUS_ACK} bus_state_t;
    typedef enum {SEQ_IDLE, SEQ_ERASE, SEQ_STREAM, SEQ_TIME} seq_state_t;

    bus_state_t busSt_reg;
    seq_state_t seqSt_reg;
    flash_ctrl_t ctrl_reg;
    logic keyHalf_reg;
    logic keyArmed_reg;
    logic [7:0] tblPage_reg;
    logic [15:0] tblEa_reg;
    logic byteMode_reg;
    logic [5:0] tune_reg;
    logic [23:0] loadAddr_reg;
    logic opWord_reg;
    logic [6:0] streamCnt_reg;
    logic timerGo_reg;
    logic timerDone;
    logic selCtrl, selKey, selPage, selPtr, selLow, selHigh, selStat, selTune;
    logic commit;
    logic byteSel;
    logic [23:0] tblAddr;
    logic [2:0] bufLanes;
    logic [23:0] bufData;
    logic [5:0] bufRdIdx;
    logic [23:0] bufRdData;
    logic startReq;
    logic startOk;
    logic opValid;
    logic seqDone;
    logic emit;
    logic [6:0] streamLast;
    logic [5:0] emitIdx;
    logic [17:0] timerCycles;
    logic [31:0] rdMux;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    always_comb begin
        selCtrl = 1'b0;
        selKey = 1'b0;
        selPage = 1'b0;
        selPtr = 1'b0;
        selLow = 1'b0;
        selHigh = 1'b0;
        selStat = 1'b0;
        selTune = 1'b0;
        if (address == OFF_CTRL) begin
            selCtrl = 1'b1;
        end else if (address == OFF_KEY) begin
            selKey = 1'b1;
        end else if (address == OFF_PAGE) begin
            selPage = 1'b1;
        end else if (address == OFF_PTR) begin
            selPtr = 1'b1;
        end else if (address == OFF_LOW) begin
            selLow = 1'b1;
        end else if (address == OFF_HIGH) begin
            selHigh = 1'b1;
        end else if (address == OFF_STAT) begin
            selStat = 1'b1;
        end else if (address == OFF_TUNE) begin
            selTune = 1'b1;
        end
    end

    // writes take effect only at the edge that ends the answer cycle
    assign commit = (busSt_reg == BUS_ACK) && write && byteenable[0];
    assign tblAddr = {tblPage_reg, tblEa_reg};
    assign byteSel = tblEa_reg[0];

    // ----------------------------------------------------------------
    // bus handshake and read data
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            busSt_reg <= BUS_IDLE;
            waitrequest <= 1'b1;
            readdata <= 32'h0;
        end else begin
            case (busSt_reg)
                BUS_IDLE: begin
                    if (read || write) begin
                        busSt_reg <= BUS_WAIT;
                    end
                end
                BUS_WAIT: begin
                    busSt_reg <= BUS_DATA;
                end
                BUS_DATA: begin
                    busSt_reg <= BUS_ACK;
                    waitrequest <= 1'b0;
                    readdata <= read ? rdMux : 32'h0;
                end
                default: begin
                    busSt_reg <= BUS_IDLE;
                    waitrequest <= 1'b1;
                end
            endcase
        end
    end

    always_comb begin
        rdMux = 32'h0;
        if (selCtrl) begin
            rdMux = {16'h0, ctrl_reg.start, ctrl_reg.wren, ctrl_reg.err, 6'h0,
                     ctrl_reg.erase, 2'h0, ctrl_reg.op};
        end else if (selPage) begin
            rdMux = {24'h0, tblPage_reg};
        end else if (selPtr) begin
            rdMux = {15'h0, byteMode_reg, tblEa_reg};
        end else if (selLow && !ctrl_reg.start) begin
            if (byteMode_reg) begin
                rdMux = {24'h0, byteSel ? arrRdData[15:8] : arrRdData[7:0]};
            end else begin
                rdMux = {16'h0, arrRdData[15:0]};
            end
        end else if (selHigh && !ctrl_reg.start) begin
            if (byteMode_reg) begin
                rdMux = {24'h0, byteSel ? 8'h00 : arrRdData[23:16]};
            end else begin
                rdMux = {16'h0, 8'h00, arrRdData[23:16]};
            end
        end else if (selStat) begin
            rdMux = {23'h0, streamCnt_reg, keyArmed_reg, ctrl_reg.start};
        end else if (selTune) begin
            rdMux = {26'h0, tune_reg};
        end
    end

    // ----------------------------------------------------------------
    // unlock key: two consecutive writes, any other write disarms
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            keyHalf_reg <= 1'b0;
            keyArmed_reg <= 1'b0;
        end else if (commit) begin
            keyHalf_reg <= 1'b0;
            keyArmed_reg <= 1'b0;
            if (selKey && writedata[7:0] == KEY_FIRST) begin
                keyHalf_reg <= 1'b1;
            end else if (selKey && keyHalf_reg && writedata[7:0] == KEY_SECOND) begin
                keyArmed_reg <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // control register and start
    // ----------------------------------------------------------------
    assign opValid = writedata[CTRL_ERASE_BIT] ? (writedata[3:0] == OP_PAGE) :
                     (writedata[3:0] == OP_ROW || writedata[3:0] == OP_WORD);
    // a start while busy is dropped outright
    assign startReq = commit && selCtrl && !ctrl_reg.start && writedata[CTRL_START_BIT];
    assign startOk = startReq && keyArmed_reg && writedata[CTRL_WREN_BIT] && opValid;
    assign seqDone = (seqSt_reg == SEQ_TIME) && timerDone;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ctrl_reg <= CTRL_RESET;
        end else begin
            if (commit && selCtrl && !ctrl_reg.start) begin
                ctrl_reg.wren <= writedata[CTRL_WREN_BIT];
                ctrl_reg.err <= writedata[CTRL_ERR_BIT];
                ctrl_reg.erase <= writedata[CTRL_ERASE_BIT];
                ctrl_reg.op <= writedata[3:0];
            end
            // hardware error set overrides the same write's clear
            if (startOk) begin
                ctrl_reg.start <= 1'b1;
            end else if (startReq) begin
                ctrl_reg.err <= 1'b1;
            end
            if (seqDone) begin
                ctrl_reg.start <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            coreStall <= 1'b0;
        end else if (startOk) begin
            coreStall <= 1'b1;
        end else if (seqDone) begin
            coreStall <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // table pointer and tuning registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            tblPage_reg <= PAGE_RESET;
            tblEa_reg <= PTR_RESET;
            byteMode_reg <= 1'b0;
            tune_reg <= TUNE_RESET;
        end else if (commit) begin
            if (selPage) begin
                tblPage_reg <= writedata[7:0];
            end else if (selPtr) begin
                tblEa_reg <= writedata[15:0];
                byteMode_reg <= writedata[PTR_BYTE_BIT];
            end else if (selTune) begin
                tune_reg <= writedata[5:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // holding buffer loads: array untouched until a start
    // ----------------------------------------------------------------
    always_comb begin
        bufLanes = 3'b000;
        if (commit && !ctrl_reg.start) begin
            if (selLow) begin
                if (!byteMode_reg) begin
                    bufLanes = 3'b011;
                end else begin
                    bufLanes = byteSel ? 3'b010 : 3'b001;
                end
            end else if (selHigh && !(byteMode_reg && byteSel)) begin
                bufLanes = 3'b100;
            end
        end
    end

    assign bufData = {writedata[7:0], byteMode_reg ? writedata[7:0] : writedata[15:8],
                      writedata[7:0]};

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            loadAddr_reg <= 24'h0;
        end else if (|bufLanes) begin
            // the row is taken from the last load; loads stay in one row
            loadAddr_reg <= {tblAddr[23:1], 1'b0};
        end
    end

    holding_buffer u_buf (
        .mclk(mclk),
        .wrLanes(bufLanes),
        .wrIdx(tblEa_reg[6:1]),
        .wrData(bufData),
        .rdIdx(bufRdIdx),
        .rdData(bufRdData)
    );

    // ----------------------------------------------------------------
    // operation sequencer
    // ----------------------------------------------------------------
    assign streamLast = opWord_reg ? 7'h01 : 7'(ROW_WORDS);
    assign bufRdIdx = opWord_reg ? loadAddr_reg[6:1] : streamCnt_reg[5:0];
    assign emit = (seqSt_reg == SEQ_STREAM) && (streamCnt_reg != 7'h0);
    assign emitIdx = 6'(streamCnt_reg - 7'h1);

    always_comb begin
        if (ctrl_reg.erase) begin
            timerCycles = 18'(PAGE_CYCLES);
        end else if (opWord_reg) begin
            timerCycles = 18'(WORD_CYCLES);
        end else begin
            timerCycles = 18'(ROW_CYCLES);
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            seqSt_reg <= SEQ_IDLE;
            streamCnt_reg <= 7'h0;
            opWord_reg <= 1'b0;
            timerGo_reg <= 1'b0;
        end else begin
            timerGo_reg <= 1'b0;
            case (seqSt_reg)
                SEQ_IDLE: begin
                    streamCnt_reg <= 7'h0;
                    if (startOk) begin
                        opWord_reg <= !writedata[CTRL_ERASE_BIT] && writedata[3:0] == OP_WORD;
                        seqSt_reg <= writedata[CTRL_ERASE_BIT] ? SEQ_ERASE : SEQ_STREAM;
                    end
                end
                SEQ_ERASE: begin
                    seqSt_reg <= SEQ_TIME;
                    timerGo_reg <= 1'b1;
                end
                SEQ_STREAM: begin
                    streamCnt_reg <= streamCnt_reg + 7'h1;
                    // exactly one row, or one word for a word program, goes out before the timed commit
                    if (streamCnt_reg == streamLast) begin
                        seqSt_reg <= SEQ_TIME;
                        timerGo_reg <= 1'b1;
                    end
                end
                default: begin
                    if (timerDone) begin
                        seqSt_reg <= SEQ_IDLE;
                    end
                end
            endcase
        end
    end

    op_timer u_timer (
        .mclk(mclk),
        .reset_n(reset_n),
        .start(timerGo_reg),
        .oscCycles(timerCycles),
        .tune(tune_reg),
        .done(timerDone)
    );

    // ----------------------------------------------------------------
    // array command port
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            arrCmd <= '0;
        end else begin
            arrCmd.read <= 1'b0;
            arrCmd.write <= 1'b0;
            arrCmd.erase <= 1'b0;
            if (seqSt_reg == SEQ_ERASE) begin
                arrCmd.erase <= 1'b1;
                arrCmd.addr <= {tblAddr[23:PAGE_ADDR_BITS], 10'h0};
                arrCmd.cfgSpace <= tblPage_reg[7];
            end else if (emit) begin
                arrCmd.write <= 1'b1;
                arrCmd.data <= bufRdData;
                arrCmd.cfgSpace <= loadAddr_reg[23];
                if (opWord_reg) begin
                    arrCmd.addr <= loadAddr_reg;
                end else begin
                    arrCmd.addr <= {loadAddr_reg[23:ROW_ADDR_BITS], emitIdx, 1'b0};
                end
            end else if (busSt_reg == BUS_IDLE && read && (selLow || selHigh)
                         && !ctrl_reg.start) begin
                arrCmd.read <= 1'b1;
                arrCmd.addr <= tblAddr;
                arrCmd.cfgSpace <= tblPage_reg[7];
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    logic [6:0] wrSeen_reg;
    always_ff @(posedge mclk) begin
        if (!reset_n || seqSt_reg == SEQ_IDLE) begin
            wrSeen_reg <= 7'h0;
        end else if (arrCmd.write) begin
            wrSeen_reg <= wrSeen_reg + 7'h1;
        end
    end

    AST_ANSWER_TIME: assert property (
        (busSt_reg == BUS_IDLE && (read || write)) |-> waitrequest [*3] ##1 !waitrequest
    ) else $error("bus answer not on fourth cycle");
    AST_ROW_COUNT: assert property (
        (seqDone && !ctrl_reg.erase && !opWord_reg) |-> wrSeen_reg == 7'd64
    ) else $error("row did not stream 64 words");
    AST_WORD_COUNT: assert property (
        (seqDone && opWord_reg) |-> wrSeen_reg == 7'd1
    ) else $error("word program streamed wrong count");
    AST_PAGE_ALIGN: assert property (
        arrCmd.erase |-> arrCmd.addr[9:0] == 10'h0
    ) else $error("erase address not page aligned");
    AST_ROW_ALIGN: assert property (
        ($rose(arrCmd.write) && !opWord_reg) |-> arrCmd.addr[6:0] == 7'h0
    ) else $error("row stream does not start on row boundary");
    AST_STALL: assert property (
        startOk |=> coreStall && ctrl_reg.start
    ) else $error("start without stall");
    AST_SELF_CLEAR: assert property (
        seqDone |=> !ctrl_reg.start && !coreStall && seqSt_reg == SEQ_IDLE
    ) else $error("start bit not cleared at end");
    AST_KEY_REFUSE: assert property (
        (startReq && !keyArmed_reg) |=> ctrl_reg.err && !ctrl_reg.start
    ) else $error("locked start not refused");
    AST_BUSY_NO_LOAD: assert property (
        ctrl_reg.start |-> bufLanes == 3'b000
    ) else $error("buffer loaded while busy");
    AST_PHANTOM: assert property (
        (busSt_reg == BUS_ACK && read && selHigh) |-> readdata[15:8] == 8'h00
    ) else $error("high read upper byte not zero");
    AST_CFG_SPACE: assert property (
        arrCmd.read |-> arrCmd.cfgSpace == arrCmd.addr[23]
    ) else $error("space select differs from page bit 7");

    COV_ROW: cover property (seqDone && !ctrl_reg.erase && !opWord_reg);
    COV_WORD: cover property (seqDone && opWord_reg);
    COV_ERASE: cover property (seqDone && ctrl_reg.erase);
    COV_REFUSE: cover property (startReq && !keyArmed_reg);
endmodule

// ---- test/flash_array_model.sv ----
// behavioural flash array that answers the sequencer's array commands
`timescale 1ns/10ps
module flash_array_model (
    input wire logic mclk,
    input wire flash_seq_pkg::flash_cmd_t arrCmd,
    output logic [23:0] arrRdData
);
    import flash_seq_pkg::*;
    logic [23:0] mem [int];
    int nWrites = 0;
    int nErases = 0;
    logic [23:0] lastAddr = 24'h000000;
    // bit 0 is the byte select; the array stores whole words
    logic [23:0] wordAddr;
    assign wordAddr = {arrCmd.addr[23:1], 1'b0};
    initial arrRdData = 24'h000000;
    always @(posedge mclk) begin
        if (arrCmd.write) begin
            mem[wordAddr] = arrCmd.data;
            nWrites++;
            lastAddr <= arrCmd.addr;
        end
        if (arrCmd.erase) begin
            nErases++;
            lastAddr <= arrCmd.addr;
        end
        // read answered one cycle later; otherwise the bus toggles so stale data never passes
        if (arrCmd.read) begin
            arrRdData <= mem.exists(wordAddr) ? mem[wordAddr] : 24'hffffff;
        end else begin
            arrRdData <= ~arrRdData;
        end
    end
endmodule

// ---- test/tb.sv ----
// self-checking bench for the flash sequencer
`timescale 1ns/10ps
module tb;
    import flash_seq_pkg::*;
    logic mclk, resetN, read, write, waitrequest, coreStall;
    logic [4:0] address;
    logic [31:0] writedata, readdata, q;
    logic [3:0] byteenable;
    logic [23:0] arrRdData;
    flash_cmd_t arrCmd;
    int nErrors = 0;
    int samplesChecked = 0;
    int cycles = 0;
    flash_row_program_sequencer #(.ROW_CYCLES(20), .PAGE_CYCLES(30), .WORD_CYCLES(5)) uut (
        .mclk(mclk), .reset_n(resetN), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .arrCmd(arrCmd), .arrRdData(arrRdData),
        .coreStall(coreStall));
    flash_array_model model (.mclk(mclk), .arrCmd(arrCmd), .arrRdData(arrRdData));
    always #4 mclk = ~mclk;
    task automatic summarize;
        if (nErrors == 0 && samplesChecked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // a hang counts as a mismatch
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            nErrors++;
            summarize;
        end
    end
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        samplesChecked++;
        if (g !== e) begin
            nErrors++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge mclk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do @(posedge mclk); while (waitrequest !== 1'b0);
        r = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task automatic runOp(input logic [31:0] c);
        logic [31:0] r;
        bus(1, OFF_KEY, 32'h55, r);
        bus(1, OFF_KEY, 32'haa, r);
        bus(1, OFF_CTRL, c, r);
        @(posedge mclk);
        check(coreStall, 32'h1);
        bus(0, OFF_LOW, 32'h0, r);
        check(r, 32'h0);
        do bus(0, OFF_STAT, 32'h0, r); while (r[0] !== 1'b0);
        check(coreStall, 32'h0);
        bus(0, OFF_CTRL, 32'h0, r);
        check(r[15], 32'h0);
    endtask
    initial begin
        mclk = 0;
        resetN = 0;
        read = 0;
        write = 0;
        address = 5'h00;
        writedata = 32'h0;
        byteenable = 4'hf;
        repeat (4) @(posedge mclk);
        resetN <= 1;
        bus(0, OFF_CTRL, 32'h0, q);
        check(q, 32'h0);
        bus(0, OFF_PAGE, 32'h0, q);
        check(q, 32'h0);
        // start without the key must be refused and flagged
        bus(1, OFF_CTRL, 32'hc001, q);
        bus(0, OFF_CTRL, 32'h0, q);
        check(q & 32'ha000, 32'h2000);
        bus(1, OFF_PAGE, 32'h01, q);
        for (int i = 0; i < 64; i++) begin
            bus(1, OFF_PTR, 32'h80 + 2 * i, q);
            bus(1, OFF_LOW, {16'h0, 8'(i), 8'(i)}, q);
            bus(1, OFF_HIGH, 32'(i + 'h40), q);
        end
        check(model.nWrites, 32'd0);
        runOp(32'hc001);
        check(model.nWrites, 32'd64);
        check(model.lastAddr, 32'h0100fe);
        bus(1, OFF_PTR, 32'h8a, q);
        bus(0, OFF_LOW, 32'h0, q);
        check(q, 32'h0505);
        bus(0, OFF_HIGH, 32'h0, q);
        check(q, 32'h45);
        bus(1, OFF_PTR, 32'h1008b, q);
        bus(0, OFF_LOW, 32'h0, q);
        check(q, 32'h05);
        bus(0, OFF_HIGH, 32'h0, q);
        check(q, 32'h0);
        bus(1, OFF_PTR, 32'h1008a, q);
        bus(0, OFF_HIGH, 32'h0, q);
        check(q, 32'h45);
        runOp(32'hc003);
        check(model.nWrites, 32'd65);
        runOp(32'hc042);
        check(model.nErases, 32'd1);
        check(model.lastAddr, 32'h010000);
        bus(1, OFF_PAGE, 32'h81, q);
        bus(0, OFF_LOW, 32'h0, q);
        check(arrCmd.cfgSpace, 32'h1);
        summarize;
    end
endmodule
